/* gpx_pkg.sv */
// package of the gpio port: register map, reset values, sense encodings
// assumes a 32-bit AXI4-Lite register bus and one 10 MHz clock
package gpx_pkg;
   // port width and the true open-drain bit positions
   localparam int          PORT_W        = 8;
   localparam logic [7:0]  TOD_MASK      = 8'h50;
   // register byte offsets
   localparam logic [7:0]  OFS_DATA      = 8'h00;
   localparam logic [7:0]  OFS_DIR       = 8'h04;
   localparam logic [7:0]  OFS_OPT       = 8'h08;
   localparam logic [7:0]  OFS_MISC1     = 8'h0C;
   localparam logic [7:0]  OFS_STATUS    = 8'h10;
   localparam logic [7:0]  OFS_MASK      = 8'h14;
   // field positions inside misc_control_one
   localparam int          SENS0_LSB     = 0;
   localparam int          SENS1_LSB     = 2;
   // values after reset
   localparam logic [1:0]  SENS_RST      = 2'h0;
   localparam logic [1:0]  IRQ_RST       = 2'h0;
   // bus answers
   localparam logic [1:0]  RESP_OKAY     = 2'h0;
   localparam logic [1:0]  RESP_SLVERR   = 2'h2;
   // event selection of one interrupt source
   typedef enum logic [1:0] {
      SENS_FALL_LOW = 2'h0,
      SENS_RISE     = 2'h1,
      SENS_FALL     = 2'h2,
      SENS_BOTH     = 2'h3
   } gpx_sens_t;
endpackage : gpx_pkg

/* gpx_sense.sv */
// event detector of one external interrupt source
// assumes levels already synchronised to clock by the caller
`timescale 1ns/1ps
`default_nettype none
module gpx_sense #(
   parameter int W = gpx_pkg::PORT_W
) (
   input  wire logic             clock,
   input  wire logic             resetn,
   input  wire logic [W-1:0]     lvl,
   input  wire logic [W-1:0]     en,
   input  wire gpx_pkg::gpx_sens_t sens,
   output logic                  evt
);
   import gpx_pkg::*;

   typedef struct packed {
      logic [W-1:0] prev;
   } gpx_sense_st_t;

   gpx_sense_st_t st_r;
   gpx_sense_st_t st_nxt;
   logic [W-1:0]  rise;
   logic [W-1:0]  fall;

   ////////////////////////////////////////////////////////////////////////
   // edges from the current sample against the previous one
   always_comb begin
      st_nxt      = st_r;
      st_nxt.prev = lvl;
      rise        = en & lvl & ~st_r.prev;
      fall        = en & ~lvl & st_r.prev;
      unique case (sens)
         SENS_RISE:     evt = |rise;
         SENS_FALL:     evt = |fall;
         SENS_BOTH:     evt = |(rise | fall);
         // low level keeps requesting for as long as the pin stays low
         SENS_FALL_LOW: evt = |fall | |(en & ~lvl);
      endcase
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   AST_RISE_FIRES: assert property (@(posedge clock) disable iff (!resetn)
      (sens == SENS_RISE && |(en & lvl & ~st_r.prev)) |-> evt)
      else $error("rising edge missed");
   AST_FALL_ONLY: assert property (@(posedge clock) disable iff (!resetn)
      (sens == SENS_FALL && evt) |-> |(en & $past(lvl) & ~lvl))
      else $error("falling event without a falling edge");
   AST_LOW_HOLDS: assert property (@(posedge clock) disable iff (!resetn)
      (sens == SENS_FALL_LOW && |(en & ~lvl))[*2] |-> evt)
      else $error("low level request dropped");
endmodule : gpx_sense
`default_nettype wire

/* gpx_port.sv */
// gpio port with pin modes, alternate function muxing and two external
// interrupt sources behind an AXI4-Lite register slave
// assumes pins come from outside the clock domain, alternate functions
// and the bus run on clock
//
// Added by the designer: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - ordinary bits give floating in, pulled-up irq in, open-drain out or push-pull out by direction and option.
// - true open-drain bits have no pull-up; option picks floating or floating irq input, output is always open-drain.
// - an input bit whose alternate function drives reads back the alternate output value.
// - an output bit feeds its data register value, not the pin, to an alternate input.
// - each irq source fires on falling, rising, both edges, or falling edge plus low level.
// - two sources with own sensitivity bits, pins grouped onto them by a non-volatile option bit.
module gpx_port #(
   parameter int         W   = gpx_pkg::PORT_W,
   parameter logic [W-1:0] TOD = gpx_pkg::TOD_MASK
) (
   input  wire logic         clock,
   input  wire logic         resetn,
   input  wire logic [31:0]  s_axi_awaddr,
   input  wire logic         s_axi_awvalid,
   output logic              s_axi_awready,
   input  wire logic [31:0]  s_axi_wdata,
   input  wire logic [3:0]   s_axi_wstrb,
   input  wire logic         s_axi_wvalid,
   output logic              s_axi_wready,
   output logic [1:0]        s_axi_bresp,
   output logic              s_axi_bvalid,
   input  wire logic         s_axi_bready,
   input  wire logic [31:0]  s_axi_araddr,
   input  wire logic         s_axi_arvalid,
   output logic              s_axi_arready,
   output logic [31:0]       s_axi_rdata,
   output logic [1:0]        s_axi_rresp,
   output logic              s_axi_rvalid,
   input  wire logic         s_axi_rready,
   input  wire logic [W-1:0] pin_in,
   output logic [W-1:0]      pin_out,
   output logic [W-1:0]      pin_oe_n,
   output logic [W-1:0]      pin_pull_en,
   input  wire logic [W-1:0] alt_out_en,
   input  wire logic [W-1:0] alt_out_val,
   output logic [W-1:0]      alt_in_val,
   input  wire logic         irq_source_grouping_option,
   output logic              irq
);
   import gpx_pkg::*;

   typedef struct packed {
      logic [W-1:0] sync1;
      logic [W-1:0] sync2;
      logic         grp1;
      logic         grp2;
      logic [W-1:0] port_data_register;
      logic [W-1:0] dir;
      logic [W-1:0] opt;
      gpx_sens_t    sens0;
      gpx_sens_t    sens1;
      logic [1:0]   status;
      logic [1:0]   mask;
      logic [W-1:0] pin_out;
      logic [W-1:0] pin_oe_n;
      logic [W-1:0] pull;
      logic [W-1:0] alt_in;
      logic         irq;
      logic         aw_held;
      logic [7:0]   aw_addr;
      logic         w_held;
      logic [31:0]  w_data;
      logic         w_lane0;
      logic         awready;
      logic         wready;
      logic         bvalid;
      logic [1:0]   bresp;
      logic         arready;
      logic         rvalid;
      logic [31:0]  rdata;
      logic [1:0]   rresp;
   } gpx_port_st_t;

   gpx_port_st_t st_r;
   gpx_port_st_t st_nxt;
   logic [W-1:0] irq_en;
   logic [W-1:0] drv;
   logic [W-1:0] push;
   logic [W-1:0] drive;
   logic [W-1:0] rd_port;
   logic [1:0]   evt;
   logic [7:0]   ar_ofs;

   // pins of group g under the grouping option: halves, or even/odd bits
   function automatic logic [W-1:0] grp_mask(input logic opt_bit,
                                             input logic g);
      logic [W-1:0] m;
      m = '0;
      for (int i = 0; i < W; i++) begin
         m[i] = opt_bit ? (i[0] == g) : ((i >= W/2) == g);
      end
      return m;
   endfunction : grp_mask

   // offset is known to the map
   function automatic logic ofs_ok(input logic [7:0] a);
      return a == OFS_DATA || a == OFS_DIR || a == OFS_OPT ||
             a == OFS_MISC1 || a == OFS_STATUS || a == OFS_MASK;
   endfunction : ofs_ok

   ////////////////////////////////////////////////////////////////////////
   // pin modes and alternate function muxing
   always_comb begin
      // alternate output wins the pin even on an input bit
      drv     = (alt_out_en & alt_out_val) |
                (~alt_out_en & st_r.port_data_register);
      drive   = st_r.dir | alt_out_en;
      // true open-drain bits never drive high
      push    = ~TOD & (st_r.opt | (alt_out_en & ~st_r.dir));
      irq_en  = ~st_r.dir & st_r.opt & ~alt_out_en;
      // read back: output bits show the latch, inputs the pin or alt value
      rd_port = (st_r.dir & st_r.port_data_register) |
                (~st_r.dir & alt_out_en & alt_out_val) |
                (~st_r.dir & ~alt_out_en & st_r.sync2);
      ar_ofs  = s_axi_araddr[7:0];
   end

   ////////////////////////////////////////////////////////////////////////
   // the two interrupt sources
   gpx_sense #(.W(W)) u_sense0 (
      .clock  (clock),
      .resetn (resetn),
      .lvl    (st_r.sync2),
      .en     (irq_en & grp_mask(st_r.grp2, 1'b0)),
      .sens   (st_r.sens0),
      .evt    (evt[0])
   );

   gpx_sense #(.W(W)) u_sense1 (
      .clock  (clock),
      .resetn (resetn),
      .lvl    (st_r.sync2),
      .en     (irq_en & grp_mask(st_r.grp2, 1'b1)),
      .sens   (st_r.sens1),
      .evt    (evt[1])
   );

   ////////////////////////////////////////////////////////////////////////
   // next state: synchronisers, pins, bus slave, interrupt status
   always_comb begin
      logic [1:0] clr;
      clr    = 2'h0;
      st_nxt = st_r;
      // two flops before any logic sees a pin or the option strap
      st_nxt.sync1    = pin_in;
      st_nxt.sync2    = st_r.sync1;
      st_nxt.grp1     = irq_source_grouping_option;
      st_nxt.grp2     = st_r.grp1;
      st_nxt.pin_oe_n = ~(drive & (push | ~drv));
      st_nxt.pin_out  = drv & push;
      st_nxt.pull     = ~st_r.dir & st_r.opt & ~TOD & ~alt_out_en;
      st_nxt.alt_in   = (st_r.dir & st_r.port_data_register) |
                        (~st_r.dir & st_r.sync2);
      // write address and data are taken in either order
      if (s_axi_awvalid && st_r.awready) begin
         st_nxt.aw_held = 1'b1;
         st_nxt.aw_addr = s_axi_awaddr[7:0];
      end
      if (s_axi_wvalid && st_r.wready) begin
         st_nxt.w_held  = 1'b1;
         st_nxt.w_data  = s_axi_wdata;
         st_nxt.w_lane0 = s_axi_wstrb[0];
      end
      if (st_r.bvalid && s_axi_bready) begin
         st_nxt.bvalid = 1'b0;
      end
      if (st_r.aw_held && st_r.w_held && !st_r.bvalid) begin
         st_nxt.aw_held = 1'b0;
         st_nxt.w_held  = 1'b0;
         st_nxt.bvalid  = 1'b1;
         st_nxt.bresp   = ofs_ok(st_r.aw_addr) ? RESP_OKAY : RESP_SLVERR;
         // all fields sit in byte lane 0
         if (st_r.w_lane0) begin
            unique case (st_r.aw_addr)
               OFS_DATA:  st_nxt.port_data_register = st_r.w_data[W-1:0];
               OFS_DIR:   st_nxt.dir  = st_r.w_data[W-1:0];
               OFS_OPT:   st_nxt.opt  = st_r.w_data[W-1:0];
               // no guard here: a change with interrupts open may glitch
               OFS_MISC1: begin
                  st_nxt.sens0 = gpx_sens_t'(st_r.w_data[SENS0_LSB +: 2]);
                  st_nxt.sens1 = gpx_sens_t'(st_r.w_data[SENS1_LSB +: 2]);
               end
               OFS_MASK:  st_nxt.mask = st_r.w_data[1:0];
               default:   st_nxt.mask = st_r.mask;
            endcase
         end
      end
      // reads answer one cycle after the address is taken
      if (st_r.rvalid && s_axi_rready) begin
         st_nxt.rvalid = 1'b0;
      end
      if (s_axi_arvalid && st_r.arready) begin
         st_nxt.rvalid = 1'b1;
         st_nxt.rresp  = ofs_ok(ar_ofs) ? RESP_OKAY : RESP_SLVERR;
         st_nxt.rdata  = 32'h0;
         unique case (ar_ofs)
            OFS_DATA:   st_nxt.rdata[W-1:0] = rd_port;
            OFS_DIR:    st_nxt.rdata[W-1:0] = st_r.dir;
            OFS_OPT:    st_nxt.rdata[W-1:0] = st_r.opt;
            OFS_MISC1:  st_nxt.rdata[3:0]   = {st_r.sens1, st_r.sens0};
            OFS_STATUS: begin
               st_nxt.rdata[1:0] = st_r.status;
               clr               = 2'h3;
            end
            OFS_MASK:   st_nxt.rdata[1:0]   = st_r.mask;
            default:    st_nxt.rdata        = 32'h0;
         endcase
      end
      // an event in the clearing cycle survives the read
      st_nxt.status  = (st_r.status & ~clr) | evt;
      st_nxt.irq     = |(st_nxt.status & st_nxt.mask);
      st_nxt.awready = !st_nxt.aw_held && !st_nxt.bvalid;
      st_nxt.wready  = !st_nxt.w_held && !st_nxt.bvalid;
      st_nxt.arready = !st_nxt.rvalid;
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         st_r          <= '0;
         st_r.sens0    <= gpx_sens_t'(SENS_RST);
         st_r.sens1    <= gpx_sens_t'(SENS_RST);
         st_r.status   <= IRQ_RST;
         st_r.mask     <= IRQ_RST;
         st_r.pin_oe_n <= '1;
         st_r.awready  <= 1'b1;
         st_r.wready   <= 1'b1;
         st_r.arready  <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   // outputs straight from flops
   assign s_axi_awready = st_r.awready;
   assign s_axi_wready  = st_r.wready;
   assign s_axi_bvalid  = st_r.bvalid;
   assign s_axi_bresp   = st_r.bresp;
   assign s_axi_arready = st_r.arready;
   assign s_axi_rvalid  = st_r.rvalid;
   assign s_axi_rdata   = st_r.rdata;
   assign s_axi_rresp   = st_r.rresp;
   assign pin_out       = st_r.pin_out;
   assign pin_oe_n      = st_r.pin_oe_n;
   assign pin_pull_en   = st_r.pull;
   assign alt_in_val    = st_r.alt_in;
   assign irq           = st_r.irq;

   ////////////////////////////////////////////////////////////////////////
   sequence s_data_read;
      s_axi_arvalid && st_r.arready && ar_ofs == OFS_DATA;
   endsequence

   AST_PUSH_PULL: assert property (@(posedge clock) disable iff (!resetn)
      (st_r.dir == '1 && st_r.opt == '1 && alt_out_en == '0) |=>
      (pin_oe_n & ~TOD) == '0 && (pin_out & ~TOD) == ($past(st_r.port_data_register) & ~TOD))
      else $error("push-pull bit not driven");
   AST_PULL_ONLY_IN: assert property (@(posedge clock) disable iff (!resetn)
      ##1 (pin_pull_en & $past(st_r.dir | ~st_r.opt)) == '0)
      else $error("pull-up on a bit not set as pulled input");
   AST_TOD_NO_HIGH: assert property (@(posedge clock) disable iff (!resetn)
      ((pin_out | pin_pull_en) & TOD) == '0)
      else $error("true open-drain bit driven high or pulled");
   AST_OD_LOW_ONLY: assert property (@(posedge clock) disable iff (!resetn)
      ##1 (~pin_oe_n & $past(~st_r.opt & st_r.dir & ~alt_out_en &
                             st_r.port_data_register)) == '0)
      else $error("open-drain bit drives while data is one");
   AST_ALT_READBACK: assert property (@(posedge clock) disable iff (!resetn)
      s_data_read |=> s_axi_rvalid &&
      (s_axi_rdata[W-1:0] & $past(~st_r.dir & alt_out_en)) ==
      ($past(alt_out_val & ~st_r.dir & alt_out_en)))
      else $error("read did not return alternate output");
   AST_ALT_IN_LATCH: assert property (@(posedge clock) disable iff (!resetn)
      ##1 (alt_in_val & $past(st_r.dir)) ==
      $past(st_r.port_data_register & st_r.dir))
      else $error("alternate input not fed from data latch");
   AST_EVT_STICKY: assert property (@(posedge clock) disable iff (!resetn)
      evt[0] |=> st_r.status[0] && (st_r.mask[0] -> irq))
      else $error("source 0 event not kept or not signalled");
   AST_SRC1_SET: assert property (@(posedge clock) disable iff (!resetn)
      evt[1] |=> st_r.status[1])
      else $error("source 1 event lost");
endmodule : gpx_port
`default_nettype wire

/* gpx_pin_model.sv */
// board-side model of the circuitry hanging on the eight port pins
// assumes the port drives pin_out/pin_oe_n/pin_pull_en from clock
`timescale 1ns/1ps
`default_nettype none
module gpx_pin_model (
   input  wire logic       clock,
   input  wire logic [7:0] pin_out,
   input  wire logic [7:0] pin_oe_n,
   input  wire logic [7:0] pin_pull_en,
   input  wire logic [7:0] ext_en,
   input  wire logic [7:0] ext_val,
   output logic      [7:0] pin_lvl
);
   // known start so the floating pattern toggles instead of staying unknown
   logic [7:0] last_r = 8'h00;
   ////////////////////////////////////////////////////////////////////////
   // wire level: port drive wins, then board driver, then pull-up; a pin
   // nobody holds flips each cycle so a stale value can never pass
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (!pin_oe_n[i]) pin_lvl[i] = pin_out[i];
         else if (ext_en[i]) pin_lvl[i] = ext_val[i];
         else if (pin_pull_en[i]) pin_lvl[i] = 1'b1;
         else pin_lvl[i] = ~last_r[i];
      end
   end
   // previous level, used only for the floating pattern
   always_ff @(posedge clock) begin
      last_r <= pin_lvl;
   end
endmodule : gpx_pin_model
`default_nettype wire

/* gpx_port_tb_top.sv */
// self-checking bench of the gpio port: AXI4-Lite tasks and pin model
// assumes gpx_pkg, gpx_port and gpx_pin_model are compiled first
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin \
   n_mismatch++; $display("Error %s expected %h seen %h", nm, e, g); end end
module gpx_port_tb_top;
   import gpx_pkg::*;
   logic        clock, resetn, awvalid, wvalid, bready, arvalid, rready;
   logic        awready, wready, bvalid, arready, rvalid, irq, grp;
   logic [31:0] awaddr, wdata, araddr, rdata;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, rs;
   logic [7:0]  pin_lvl, pin_out, oe_n, pull, ext_en, ext_val;
   logic [7:0]  alt_en, alt_val, alt_in;
   logic [31:0] rd;
   int          n_mismatch, cmp_count, cyc;
   gpx_port i_gpx_port (.clock(clock), .resetn(resetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pin_in(pin_lvl),
      .pin_out(pin_out), .pin_oe_n(oe_n), .pin_pull_en(pull),
      .alt_out_en(alt_en), .alt_out_val(alt_val), .alt_in_val(alt_in),
      .irq_source_grouping_option(grp), .irq(irq));
   gpx_pin_model i_gpx_pin_model (.clock(clock), .pin_out(pin_out),
      .pin_oe_n(oe_n), .pin_pull_en(pull), .ext_en(ext_en),
      .ext_val(ext_val), .pin_lvl(pin_lvl));
   ///////////////////////////////////////////////////////////////////////////
   // clock and hang guard; the run needs well under 5000 cycles
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end
   always @(posedge clock) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         end_sim();
      end
   end
   task automatic end_sim();
      $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : end_sim
   ///////////////////////////////////////////////////////////////////////////
   // bus tasks: entered right after a rising edge, registered outputs are
   // read before that edge's updates land
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] st);
      awaddr <= {24'h0, a};
      wdata <= d;
      wstrb <= st;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clock);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (!bvalid);
      // bready stays high: lowering it here would collide with the next call
      rs = bresp;
   endtask : wr
   task automatic rdr(input logic [7:0] a);
      araddr <= {24'h0, a};
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clock);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (!rvalid);
      rd = rdata;
      rs = rresp;
   endtask : rdr
   task automatic w8(input logic [7:0] a, input logic [7:0] d);
      wr(a, {24'h0, d}, 4'hF);
   endtask : w8
   task automatic pins(input logic [7:0] v);
      ext_val <= v;
      repeat (6) @(posedge clock);
   endtask : pins
   // quiet the sources, change sensitivity, clear status, unmask
   task automatic sense(input logic [1:0] s, input logic [1:0] m);
      w8(OFS_MASK, 8'h00);
      w8(OFS_MISC1, {4'h0, s, s});
      pins(8'hFF);
      rdr(OFS_STATUS);
      w8(OFS_MASK, {6'h0, m});
   endtask : sense
   ///////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      logic [7:0] ofs [5] = '{OFS_DIR, OFS_OPT, OFS_MISC1, OFS_STATUS, OFS_MASK};
      logic [1:0] s;
      {resetn, awvalid, wvalid, bready, arvalid, rready, grp} = '0;
      {awaddr, wdata, araddr} = '0;
      {wstrb, ext_en, ext_val, alt_en, alt_val} = '0;
      repeat (4) @(posedge clock);
      resetn <= 1'b1;
      @(posedge clock);
      // reset values, a lane-0-less write and an unmapped read
      foreach (ofs[i]) begin
         rdr(ofs[i]);
         `CHK("reset value", 32'h0, rd)
      end
      wr(OFS_DIR, 32'hFF, 4'hE);
      `CHK("strobe resp", RESP_OKAY, rs)
      rdr(OFS_DIR);
      `CHK("strobe ignored", 32'h0, rd)
      rdr(8'h40);
      `CHK("unmapped resp", RESP_SLVERR, rs)
      `CHK("unmapped data", 32'h0, rd)
      // direction x option on ordinary bit 0 and true open-drain bit 4
      for (int c = 0; c < 4; c++) begin
         w8(OFS_DATA, 8'hFF);
         w8(OFS_DIR, c[1] ? 8'hFF : 8'h00);
         w8(OFS_OPT, c[0] ? 8'hFF : 8'h00);
         repeat (2) @(posedge clock);
         `CHK("modes", {1'b1, c != 3, 1'b0, c == 1}, {oe_n[4], oe_n[0], pull[4], pull[0]})
      end
      w8(OFS_DATA, 8'h00);
      repeat (2) @(posedge clock);
      `CHK("drive low", 16'h0000, {oe_n, pin_out})
      // output bits feed the latch, not the pin, to the alternate input
      w8(OFS_OPT, 8'h00);
      w8(OFS_DATA, 8'hA5);
      ext_en <= 8'hFF;
      pins(8'h00);
      `CHK("alt input", 8'hA5, alt_in)
      // input bit driven by its alternate function reads back that value
      w8(OFS_DIR, 8'h00);
      // true open-drain bit 4 releases its one, so the pin reads 0 there
      alt_en <= 8'h10;
      alt_val <= 8'h10;
      pins(8'h4A);
      rdr(OFS_DATA);
      `CHK("alt readback", 32'h5A, rd)
      alt_en <= 8'h00;
      alt_val <= 8'h00;
      // every sensitivity code on both sources, default grouping
      w8(OFS_OPT, 8'hFF);
      for (int k = 0; k < 4; k++) begin
         s = k[1:0];
         sense(s, 2'h3);
         pins(8'hFE);
         `CHK("irq fall", s != SENS_RISE, irq)
         rdr(OFS_STATUS);
         `CHK("fall", {31'h0, s != SENS_RISE}, rd)
         rdr(OFS_STATUS);
         `CHK("low level", {31'h0, s == SENS_FALL_LOW}, rd)
         pins(8'hFF);
         rdr(OFS_STATUS);
         // falling+low re-sets while the pin is still low before the rise
         `CHK("rise", {31'h0, s != SENS_FALL}, rd)
         pins(8'hEF);
         rdr(OFS_STATUS);
         `CHK("source1 fall", {30'h0, s != SENS_RISE, 1'b0}, rd)
         `CHK("irq cleared", s == SENS_FALL_LOW, irq)
      end
      // odd grouping: bit 1 feeds source 1, masked off
      grp <= 1'b1;
      sense(SENS_FALL, 2'h1);
      pins(8'hFD);
      `CHK("masked irq", 1'b0, irq)
      rdr(OFS_STATUS);
      `CHK("odd group", 32'h2, rd)
      end_sim();
   end
endmodule : gpx_port_tb_top
`default_nettype wire
